// [fsp_defs.svh]
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// Flash geometry
`define FSP_PC_W 12
`define FSP_PAGE_W 7
`define FSP_WORD_W 5
`define FSP_PAGE_WORDS 32
`define FSP_FLASH_WORDS 4096
`define FSP_Z_PAGE_HI 12
`define FSP_Z_PAGE_LO 6
`define FSP_Z_WORD_HI 5
`define FSP_Z_WORD_LO 1
`define FSP_Z_BYTE 0
`define FSP_BLOCKING_START 12'hC00
`define FSP_ERASED_WORD 16'hFFFF
`define FSP_BLOCKED_BYTE 8'hFF

// Boot reset addresses per size code
`define FSP_BOOT_128 12'hF80
`define FSP_BOOT_256 12'hF00
`define FSP_BOOT_512 12'hE00
`define FSP_BOOT_1024 12'hC00

// Control register bit positions
`define FSP_BIT_ENABLE 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_REENABLE 4
`define FSP_BIT_BUSY 6

// Timed sequence window in clock cycles
`define FSP_WINDOW_CYC 3'h4
`define FSP_WINDOW_W 3

// Programming time, counted in RC oscillator ticks
`define FSP_RC_KHZ 1000
`define FSP_OP_MIN_US 3700
`define FSP_OP_MAX_US 4500
`define FSP_OP_TICKS ((((`FSP_OP_MIN_US) + (`FSP_OP_MAX_US)) / 2) * (`FSP_RC_KHZ) / 1000)
`define FSP_TIMER_W 13

`endif

// [fsp_pkg.sv]
`include "fsp_defs.svh"

package fsp_pkg;

  typedef logic [`FSP_PC_W-1:0] fsp_word_addr_t;

  typedef enum logic [1:0] {
    FSP_CMD_FILL = 2'h0,
    FSP_CMD_ERASE = 2'h1,
    FSP_CMD_WRITE = 2'h2,
    FSP_CMD_REENABLE = 2'h3
  } fsp_cmd_e;

  typedef enum logic [1:0] {
    FSP_ENG_IDLE = 2'b01,
    FSP_ENG_RUN = 2'b10
  } fsp_eng_e;

  typedef enum logic [3:0] {
    FSP_HOST_IDLE = 4'b0001,
    FSP_HOST_WAIT = 4'b0010,
    FSP_HOST_CTRL = 4'b0100,
    FSP_HOST_STORE = 4'b1000
  } fsp_host_e;

endpackage : fsp_pkg

// [fsp_link_if.sv]
`timescale 1ns/1ps
interface fsp_link_if (
  input wire logic clock,
  input wire logic resetn
);
  logic ctrlWrite;
  logic [7:0] ctrlData;
  logic [7:0] ctrlRead;
  logic storeStrobe;
  logic [15:0] zPtr;
  logic [15:0] storeData;
  logic loadReq;
  logic [15:0] loadAddr;
  logic loadValid;
  logic [7:0] loadData;
  logic [11:0] fetchAddr;
  logic fetchOk;
  logic eepromWritePending;

  modport device (
    input clock, resetn, ctrlWrite, ctrlData, storeStrobe, zPtr, storeData,
    input loadReq, loadAddr, fetchAddr, eepromWritePending,
    output ctrlRead, loadValid, loadData, fetchOk
  );

  modport host (
    input clock, resetn, ctrlRead, loadValid, loadData, fetchOk, eepromWritePending,
    output ctrlWrite, ctrlData, storeStrobe, zPtr, storeData, loadReq, loadAddr, fetchAddr
  );
endinterface : fsp_link_if

// [fsp_seq_device.sv]
// Summary of operation
// - Reset does not abort running erase/write
// - Operation time counted in RC oscillator ticks
// - Each erase/write lasts 3.7 to 4.5 ms
// - Boot size code selects boot reset address
// - Application area is words 0x000-0xBFF
// - Only 0xC00-0xFFF readable during erase/write
// - Word addresses are 12 bits wide
// - Page of 32 words, word from Z5:Z1
// - Page number taken from Z12:Z6
// - Software zeroes word field for page write
// - Pointer bits Z15:Z13 are ignored
// - Z0 zero for commands, byte select for loads
// - Software: erase, reenable, fill, write, reenable
// - Software polls enable and EEPROM pending first
// - Application area unreadable while busy flag set
// - Store must follow control write within 4 cycles
// - Busy stays set until reenable command
`timescale 1ns/1ps
`include "fsp_defs.svh"

module fsp_seq_device
  import fsp_pkg::*;
#(
  parameter int unsigned OP_TICKS = `FSP_OP_TICKS
) (
  fsp_link_if.device link,
  input wire logic powerOnResetn,
  input wire logic rcTick,
  input wire logic [1:0] bootSizeSel,
  output logic [`FSP_PC_W-1:0] bootResetAddr,
  output logic opActive
);

  // Application area test, shared by loads and fetches
  function automatic logic inConcurrentArea(input fsp_word_addr_t addr);
    inConcurrentArea = (addr < `FSP_BLOCKING_START);
  endfunction : inConcurrentArea

  function automatic fsp_word_addr_t bootAddr(input logic [1:0] sel);
    case (sel)
      2'h3: bootAddr = `FSP_BOOT_128;
      2'h2: bootAddr = `FSP_BOOT_256;
      2'h1: bootAddr = `FSP_BOOT_512;
      default: bootAddr = `FSP_BOOT_1024;
    endcase
  endfunction : bootAddr

  logic [15:0] flash [0:`FSP_FLASH_WORDS-1];
  logic [15:0] pageBuf [0:`FSP_PAGE_WORDS-1];

  // Control group, cleared by the ordinary reset
  logic enable;
  logic eraseSel;
  logic writeSel;
  logic reenableSel;
  logic [`FSP_WINDOW_W-1:0] window;
  logic next_enable;
  logic next_eraseSel;
  logic next_writeSel;
  logic next_reenableSel;
  logic [`FSP_WINDOW_W-1:0] next_window;

  // Engine group, cleared only at power-on
  fsp_eng_e engState;
  fsp_eng_e next_engState;
  logic [`FSP_TIMER_W-1:0] timer;
  logic [`FSP_TIMER_W-1:0] next_timer;
  logic [`FSP_PAGE_W-1:0] opPage;
  logic [`FSP_PAGE_W-1:0] next_opPage;
  logic opWrite;
  logic next_opWrite;
  logic busy;
  logic next_busy;

  // Load group
  logic loadValid;
  logic next_loadValid;
  logic [7:0] loadData;
  logic [7:0] next_loadData;
  logic [`FSP_PC_W-1:0] next_bootResetAddr;

  // Command decode
  logic storeTaken;
  logic startOp;
  logic reenablePulse;
  logic bufWe;
  logic opDone;
  logic [15:0] loadWord;
  fsp_word_addr_t loadWordAddr;

  always_comb begin
    // Store counts only inside the window
    // Commands with Z0 set are ignored
    storeTaken = (window != '0) && link.storeStrobe && !link.zPtr[`FSP_Z_BYTE];
    startOp = storeTaken && (eraseSel || writeSel) && (engState == FSP_ENG_IDLE);
    reenablePulse = storeTaken && reenableSel && !eraseSel && !writeSel;
    bufWe = storeTaken && !eraseSel && !writeSel && !reenableSel;
  end

  always_comb begin
    next_enable = enable;
    next_eraseSel = eraseSel;
    next_writeSel = writeSel;
    next_reenableSel = reenableSel;
    next_window = window;
    if (link.ctrlWrite && !enable && !link.eepromWritePending) begin
      // Set wins over completion; enable is only low here after a bus reset
      // EEPROM write in progress locks out the control register
      next_enable = link.ctrlData[`FSP_BIT_ENABLE];
      next_eraseSel = link.ctrlData[`FSP_BIT_ERASE];
      next_writeSel = link.ctrlData[`FSP_BIT_WRITE];
      next_reenableSel = link.ctrlData[`FSP_BIT_REENABLE];
      next_window = link.ctrlData[`FSP_BIT_ENABLE] ? `FSP_WINDOW_CYC : '0;
    end else if (opDone) begin
      next_enable = 1'b0;
      next_eraseSel = 1'b0;
      next_writeSel = 1'b0;
    end else if (window != '0) begin
      next_window = window - 1'b1;
      if (startOp) begin
        // Enable stays set while the timed operation runs
        next_window = '0;
        next_reenableSel = 1'b0;
      end else if (storeTaken || window == `FSP_WINDOW_W'(1)) begin
        next_window = '0;
        next_enable = 1'b0;
        next_eraseSel = 1'b0;
        next_writeSel = 1'b0;
        next_reenableSel = 1'b0;
      end
    end
  end

  always_ff @(posedge link.clock or negedge link.resetn) begin
    if (!link.resetn) begin
      enable <= 1'b0;
      eraseSel <= 1'b0;
      writeSel <= 1'b0;
      reenableSel <= 1'b0;
      window <= '0;
    end else begin
      enable <= next_enable;
      eraseSel <= next_eraseSel;
      writeSel <= next_writeSel;
      reenableSel <= next_reenableSel;
      window <= next_window;
    end
  end

  always_comb begin
    next_engState = engState;
    next_timer = timer;
    next_opPage = opPage;
    next_opWrite = opWrite;
    next_busy = busy;
    opDone = 1'b0;
    case (engState)
      FSP_ENG_IDLE: begin
        if (startOp) begin
          next_engState = FSP_ENG_RUN;
          // Duration between min and max time
          next_timer = `FSP_TIMER_W'(OP_TICKS - 1);
          // Page from Z12:Z6, upper bits dropped
          next_opPage = link.zPtr[`FSP_Z_PAGE_HI:`FSP_Z_PAGE_LO];
          next_opWrite = writeSel;
          next_busy = 1'b1;
        end else if (reenablePulse) begin
          next_busy = 1'b0;
        end
      end
      FSP_ENG_RUN: begin
        // Time base is the RC oscillator tick
        if (rcTick) begin
          if (timer == '0) begin
            next_engState = FSP_ENG_IDLE;
            opDone = 1'b1;
          end else begin
            next_timer = timer - 1'b1;
          end
        end
      end
      default: begin
        next_engState = FSP_ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge link.clock or negedge powerOnResetn) begin
    if (!powerOnResetn) begin
      engState <= FSP_ENG_IDLE;
      timer <= '0;
      opPage <= '0;
      opWrite <= 1'b0;
      busy <= 1'b0;
    end else begin
      engState <= next_engState;
      timer <= next_timer;
      opPage <= next_opPage;
      opWrite <= next_opWrite;
      busy <= next_busy;
    end
  end

  // Array contents are non-volatile and take no reset
  always_ff @(posedge link.clock) begin
    if (bufWe) begin
      pageBuf[link.zPtr[`FSP_Z_WORD_HI:`FSP_Z_WORD_LO]] <= link.storeData;
    end
    if (opDone) begin
      for (int i = 0; i < `FSP_PAGE_WORDS; i++) begin
        flash[{opPage, `FSP_WORD_W'(i)}] <= opWrite ? pageBuf[i] : `FSP_ERASED_WORD;
      end
    end
  end

  always_comb begin
    loadWordAddr = link.loadAddr[`FSP_PC_W:1];
    loadWord = flash[loadWordAddr];
    next_loadValid = link.loadReq;
    next_loadData = loadData;
    next_bootResetAddr = bootAddr(bootSizeSel);
    if (link.loadReq) begin
      if (busy && inConcurrentArea(loadWordAddr)) begin
        // Busy area reads back as blank
        next_loadData = `FSP_BLOCKED_BYTE;
      end else begin
        next_loadData = link.loadAddr[`FSP_Z_BYTE] ? loadWord[15:8] : loadWord[7:0];
      end
    end
  end

  always_ff @(posedge link.clock or negedge link.resetn) begin
    if (!link.resetn) begin
      loadValid <= 1'b0;
      loadData <= '0;
      bootResetAddr <= `FSP_BOOT_1024;
    end else begin
      loadValid <= next_loadValid;
      loadData <= next_loadData;
      bootResetAddr <= next_bootResetAddr;
    end
  end

  // Only the blocking area fetches while busy
  assign link.fetchOk = !(busy && inConcurrentArea(link.fetchAddr));
  assign link.loadValid = loadValid;
  assign link.loadData = loadData;
  assign opActive = (engState == FSP_ENG_RUN);

  always_comb begin
    link.ctrlRead = '0;
    link.ctrlRead[`FSP_BIT_ENABLE] = enable;
    link.ctrlRead[`FSP_BIT_ERASE] = eraseSel;
    link.ctrlRead[`FSP_BIT_WRITE] = writeSel;
    link.ctrlRead[`FSP_BIT_REENABLE] = reenableSel;
    // Busy flag visible to polling software
    link.ctrlRead[`FSP_BIT_BUSY] = busy;
  end

endmodule : fsp_seq_device

// [fsp_cpu_host.sv]
`timescale 1ns/1ps
`include "fsp_defs.svh"

module fsp_cpu_host
  import fsp_pkg::*;
(
  fsp_link_if.host link,
  input wire logic cmdValid,
  input wire fsp_cmd_e cmdKind,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdData,
  output logic cmdReady,
  output logic cmdDone,
  input wire logic readReq,
  input wire logic [15:0] readAddr,
  output logic readValid,
  output logic [7:0] readData,
  input wire logic [11:0] fetchAddrIn,
  output logic fetchOk,
  output logic busyStatus
);

  fsp_host_e state;
  fsp_host_e next_state;
  logic [7:0] ctrlValue;
  logic [7:0] next_ctrlValue;
  logic [15:0] zValue;
  logic [15:0] next_zValue;
  logic [15:0] dataValue;
  logic [15:0] next_dataValue;
  logic loadReq;
  logic [15:0] loadAddr;
  logic [7:0] rdData;
  logic rdValid;
  logic next_loadReq;
  logic [15:0] next_loadAddr;
  logic [7:0] next_rdData;
  logic next_rdValid;

  always_comb begin
    next_loadReq = readReq;
    next_loadAddr = readReq ? readAddr : loadAddr;
    next_rdValid = link.loadValid;
    next_rdData = link.loadValid ? link.loadData : rdData;
  end

  always_comb begin
    next_state = state;
    next_ctrlValue = ctrlValue;
    next_zValue = zValue;
    next_dataValue = dataValue;
    case (state)
      FSP_HOST_IDLE: begin
        if (cmdValid) begin
          next_state = FSP_HOST_WAIT;
          next_ctrlValue = '0;
          next_ctrlValue[`FSP_BIT_ENABLE] = 1'b1;
          next_ctrlValue[`FSP_BIT_ERASE] = (cmdKind == FSP_CMD_ERASE);
          next_ctrlValue[`FSP_BIT_WRITE] = (cmdKind == FSP_CMD_WRITE);
          next_ctrlValue[`FSP_BIT_REENABLE] = (cmdKind == FSP_CMD_REENABLE);
          next_zValue = {cmdAddr[15:1], 1'b0};
          if (cmdKind == FSP_CMD_WRITE) begin
            // Word field zeroed for page write
            next_zValue[`FSP_Z_WORD_HI:`FSP_Z_WORD_LO] = '0;
          end
          next_dataValue = cmdData;
        end
      end
      FSP_HOST_WAIT: begin
        if (!link.ctrlRead[`FSP_BIT_ENABLE] && !link.eepromWritePending) begin
          next_state = FSP_HOST_CTRL;
        end
      end
      FSP_HOST_CTRL: begin
        next_state = FSP_HOST_STORE;
      end
      FSP_HOST_STORE: begin
        next_state = FSP_HOST_IDLE;
      end
      default: begin
        next_state = FSP_HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge link.clock or negedge link.resetn) begin
    if (!link.resetn) begin
      state <= FSP_HOST_IDLE;
      ctrlValue <= '0;
      zValue <= '0;
      dataValue <= '0;
      loadReq <= 1'b0;
      loadAddr <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else begin
      state <= next_state;
      ctrlValue <= next_ctrlValue;
      zValue <= next_zValue;
      dataValue <= next_dataValue;
      loadReq <= next_loadReq;
      loadAddr <= next_loadAddr;
      rdValid <= next_rdValid;
      rdData <= next_rdData;
    end
  end

  // Store issued the cycle after the control write
  assign link.ctrlWrite = (state == FSP_HOST_CTRL);
  assign link.storeStrobe = (state == FSP_HOST_STORE);
  assign link.ctrlData = ctrlValue;
  assign link.zPtr = zValue;
  assign link.storeData = dataValue;
  assign link.loadReq = loadReq;
  assign link.loadAddr = loadAddr;
  assign link.fetchAddr = fetchAddrIn;
  assign cmdReady = (state == FSP_HOST_IDLE);
  assign cmdDone = (state == FSP_HOST_STORE);
  assign readValid = rdValid;
  assign readData = rdData;
  assign fetchOk = link.fetchOk;
  // Busy reported for the reenable loop
  assign busyStatus = link.ctrlRead[`FSP_BIT_BUSY];

endmodule : fsp_cpu_host

// [fsp_seq_monitor.sv]
`timescale 1ns/1ps
module fsp_seq_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlRead,
  input wire logic storeStrobe,
  input wire logic [15:0] zPtr,
  input wire logic loadReq,
  input wire logic [15:0] loadAddr,
  input wire logic loadValid,
  input wire logic [7:0] loadData,
  input wire logic [11:0] fetchAddr,
  input wire logic fetchOk,
  input wire logic eepromWritePending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_load_answer: assert property (loadReq |=> loadValid)
    else $error("load not answered");
  chk_blocked_load: assert property (loadReq && ctrlRead[6] && loadAddr[12:1] < 12'hC00
    |=> loadData == 8'hFF)
    else $error("blocked load returned data");
  chk_fetch_split: assert property (ctrlRead[6] |-> fetchOk == (fetchAddr >= 12'hC00))
    else $error("fetch permission wrong while busy");
  chk_poll_before: assert property (ctrlWrite |-> !ctrlRead[0] && !eepromWritePending)
    else $error("control write while not ready");
  chk_store_window: assert property (ctrlWrite |-> ##[1:4] storeStrobe)
    else $error("store missed its window");
  chk_store_zero: assert property (storeStrobe |-> !zPtr[0])
    else $error("store with byte bit set");
  chk_write_word: assert property (storeStrobe && ctrlRead[2] |-> zPtr[5:1] == 5'h00)
    else $error("page write with word field set");
  chk_busy_start: assert property (storeStrobe && ctrlRead[0] && (ctrlRead[1] || ctrlRead[2]) && !ctrlRead[6]
    |=> ctrlRead[6])
    else $error("busy not set by erase or write");
  chk_busy_release: assert property ($fell(ctrlRead[6]) |-> $past(storeStrobe) || $past(storeStrobe, 2))
    else $error("busy cleared without store");
  chk_fill_clear: assert property (storeStrobe && ctrlRead[0] && ctrlRead[4:1] == 4'h0 && !ctrlRead[6]
    |-> ##[1:2] !ctrlRead[0])
    else $error("fill left enable set");
endmodule : fsp_seq_monitor

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  import fsp_pkg::*;
  localparam int OPT = 8;
  // RC tick runs at a third of the clock, so op length proves the RC source
  localparam int SPAN = OPT * 3;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic powerOnResetn = 1'b0;
  logic [1:0] tickDiv = 2'h0;
  logic [1:0] bootSizeSel = 2'h0;
  logic cmdValid = 1'b0;
  fsp_cmd_e cmdKind = FSP_CMD_FILL;
  logic [15:0] cmdAddr = 16'h0000;
  logic [15:0] cmdData = 16'h0000;
  logic readReq = 1'b0;
  logic [15:0] readAddr = 16'h0000;
  logic [11:0] fetchAddrIn = 12'h000;
  logic eePending = 1'b0;
  wire logic [11:0] bootResetAddr;
  wire logic opActive;
  wire logic cmdReady;
  wire logic cmdDone;
  wire logic readValid;
  wire logic [7:0] readData;
  wire logic fetchOk;
  wire logic busyStatus;
  int mismatches = 0;
  int cmp_count = 0;

  fsp_link_if link (.clock(clock), .resetn(resetn));
  assign link.eepromWritePending = eePending;

  fsp_seq_device #(.OP_TICKS(OPT)) fsp_seq_device_i (.link(link.device), .powerOnResetn(powerOnResetn),
    .rcTick(tickDiv == 2'h2), .bootSizeSel(bootSizeSel), .bootResetAddr(bootResetAddr), .opActive(opActive));
  fsp_cpu_host fsp_cpu_host_i (.link(link.host), .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdReady(cmdReady), .cmdDone(cmdDone), .readReq(readReq), .readAddr(readAddr),
    .readValid(readValid), .readData(readData), .fetchAddrIn(fetchAddrIn), .fetchOk(fetchOk),
    .busyStatus(busyStatus));
  fsp_seq_monitor fsp_seq_monitor_i (.clock(link.clock), .resetn(link.resetn), .ctrlWrite(link.ctrlWrite),
    .ctrlRead(link.ctrlRead), .storeStrobe(link.storeStrobe), .zPtr(link.zPtr), .loadReq(link.loadReq),
    .loadAddr(link.loadAddr), .loadValid(link.loadValid), .loadData(link.loadData),
    .fetchAddr(link.fetchAddr), .fetchOk(link.fetchOk), .eepromWritePending(link.eepromWritePending));

  always #4 clock = ~clock;
  always @(posedge clock) tickDiv <= (tickDiv == 2'h2) ? 2'h0 : tickDiv + 2'h1;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Outputs are sampled on the falling edge so they have settled
  task automatic issue(input fsp_cmd_e k, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (n < 2000) begin
      @(negedge clock);
      if (cmdReady === 1'b1) break;
      n++;
    end
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clock);
    cmdValid <= 1'b0;
    n = 0;
    while (n < 2000) begin
      @(negedge clock);
      if (cmdDone === 1'b1) break;
      n++;
    end
    `CHK(cmdDone, 1'b1)
  endtask : issue

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    readReq <= 1'b1;
    readAddr <= a;
    @(posedge clock);
    readReq <= 1'b0;
    while (n < 20) begin
      @(negedge clock);
      if (readValid === 1'b1) break;
      n++;
    end
    d = (n < 20) ? readData : 8'hXX;
  endtask : rd

  // Counts from the call until the timed operation has ended
  task automatic wait_op(output int dur);
    dur = 0;
    while (dur < 500 && (dur < 3 || opActive === 1'b1)) begin
      @(negedge clock);
      dur++;
    end
  endtask : wait_op

  task automatic t_boot;
    logic [11:0] exp [4];
    exp = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      bootSizeSel <= i[1:0];
      repeat (2) @(negedge clock);
      `CHK(bootResetAddr, exp[i])
    end
  endtask : t_boot

  task automatic t_page;
    int dur;
    logic [7:0] b;
    issue(FSP_CMD_ERASE, 16'hA840, 16'h0000);
    wait_op(dur);
    `CHK(dur inside {[SPAN - 3:SPAN + 4]}, 1'b1)
    `CHK(link.ctrlRead[0], 1'b0)
    issue(FSP_CMD_REENABLE, 16'h0000, 16'h0000);
    for (int w = 0; w < 32; w++) begin
      issue(FSP_CMD_FILL, 16'h0840 | 16'(w << 1), 16'h5A00 | 16'(w));
    end
    issue(FSP_CMD_WRITE, 16'hA840, 16'h0000);
    @(posedge clock);
    fetchAddrIn <= 12'h420;
    @(negedge clock);
    `CHK(fetchOk, 1'b0)
    `CHK(busyStatus, 1'b1)
    @(posedge clock);
    fetchAddrIn <= 12'hC40;
    @(negedge clock);
    `CHK(fetchOk, 1'b1)
    rd(16'h0840, b);
    `CHK(b, 8'hFF)
    wait_op(dur);
    `CHK(link.ctrlRead[0], 1'b0)
    `CHK(busyStatus, 1'b1)
    issue(FSP_CMD_REENABLE, 16'h0000, 16'h0000);
    @(negedge clock);
    `CHK(busyStatus, 1'b0)
    rd(16'hE84A, b);
    `CHK(b, 8'h05)
    rd(16'h084B, b);
    `CHK(b, 8'h5A)
    rd(16'h087E, b);
    `CHK(b, 8'h1F)
  endtask : t_page

  task automatic t_eeprom;
    logic seen;
    seen = 1'b0;
    @(posedge clock);
    eePending <= 1'b1;
    fork
      issue(FSP_CMD_FILL, 16'h0840, 16'h1234);
      begin
        repeat (12) begin
          @(negedge clock);
          seen = seen | cmdDone;
        end
        `CHK(seen, 1'b0)
        @(posedge clock);
        eePending <= 1'b0;
      end
    join
  endtask : t_eeprom

  // Only the bus reset is pulsed; the running erase must survive it
  task automatic t_reset;
    int dur;
    logic [7:0] b;
    issue(FSP_CMD_ERASE, 16'h0840, 16'h0000);
    repeat (4) @(posedge clock);
    resetn <= 1'b0;
    @(negedge clock);
    // Core held in reset issues no stray control write
    `CHK(link.ctrlWrite, 1'b0)
    `CHK(busyStatus, 1'b1)
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    `CHK(opActive, 1'b1)
    wait_op(dur);
    issue(FSP_CMD_REENABLE, 16'h0000, 16'h0000);
    rd(16'h084A, b);
    `CHK(b, 8'hFF)
  endtask : t_reset

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    powerOnResetn <= 1'b1;
    t_boot();
    t_page();
    t_eeprom();
    t_reset();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    finish_test();
  end
endmodule : testbench
